// >>> bench/tmr3_timer_asserts.sv
// Port checker for the third timer control block
`timescale 1ns/1ps
module tmr3_timer_asserts (
  // Clock and reset
  input wire i_clk,
  input wire i_rstn,
  // Register port and interrupt
  input wire [7:0] i_sfr_addr,
  input wire i_sfr_wr,
  input wire [7:0] i_sfr_wdata,
  input wire [7:0] o_sfr_rdata,
  input wire i_extended_irq_enable_one,
  input wire o_irq
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  sequence ctl;
    (i_sfr_addr == 8'h91 && !i_sfr_wr) ##1 (i_sfr_addr == 8'h91);
  endsequence
  a_irq_gated: assert property (!i_extended_irq_enable_one |=> !o_irq)
    else $error("irq without enable");
  a_unmapped_zero: assert property ((i_sfr_addr < 8'h91 || i_sfr_addr > 8'h95) |=> o_sfr_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_reset_clear: assert property ($rose(i_rstn) |-> o_sfr_rdata == 8'h00 && !o_irq)
    else $error("outputs not clear after reset");
  a_ctrl_readback: assert property ((i_sfr_wr && i_sfr_addr == 8'h91) ##1 (i_sfr_addr == 8'h91)
    |=> o_sfr_rdata[5:0] == $past(i_sfr_wdata[5:0], 2)) else $error("control readback wrong");
  a_ctrl_holds: assert property (ctl |=> o_sfr_rdata[5:0] == $past(o_sfr_rdata[5:0]))
    else $error("control changed without write");
  a_flags_sticky: assert property (ctl |=> (o_sfr_rdata[7:6] & $past(o_sfr_rdata[7:6])) == $past(o_sfr_rdata[7:6]))
    else $error("flag cleared by hardware");
  a_high_irq: assert property (ctl ##0 (o_sfr_rdata[7] && i_extended_irq_enable_one) |=> o_irq)
    else $error("high flag gave no irq");
  a_low_irq: assert property (ctl ##0 (o_sfr_rdata[6] && o_sfr_rdata[5] && i_extended_irq_enable_one) |=> o_irq)
    else $error("low flag gave no irq");
  c_high_flag: cover property (ctl ##0 o_sfr_rdata[7]);
  c_irq_rise: cover property ($rose(o_irq));
  c_ctrl_write: cover property (i_sfr_wr && i_sfr_addr == 8'h91);
endmodule

bind tmr3_timer tmr3_timer_asserts u_chk (.i_clk, .i_rstn, .i_sfr_addr, .i_sfr_wr, .i_sfr_wdata, .o_sfr_rdata,
  .i_extended_irq_enable_one, .o_irq);

// >>> bench/tmr3_timer_test.sv
// Self-checking testbench for the third timer control block
`timescale 1ns/1ps
module tmr3_timer_test;
  reg i_clk = 0;
  reg i_rstn = 0;
  reg wr_en = 0;
  reg hsel = 0;
  reg lsel = 0;
  reg irq_en = 0;
  reg ext = 0;
  reg lfo = 1;
  reg seen = 0;
  reg [7:0] addr = 8'h00;
  reg [7:0] wdata = 8'h00;
  reg [7:0] v;
  reg [7:0] w;
  wire [7:0] rdata;
  wire irq;
  integer failures = 0;
  integer n_checks = 0;
  integer i;
  integer e;
  tmr3_timer dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_sfr_addr(addr), .i_sfr_wr(wr_en), .i_sfr_wdata(wdata),
    .o_sfr_rdata(rdata), .i_high_byte_clock_select(hsel), .i_low_byte_clock_select(lsel),
    .i_extended_irq_enable_one(irq_en), .i_ext_clk(ext), .i_lfo_out(lfo), .o_irq(irq));
  initial begin
    forever #4 i_clk = ~i_clk;
  end
  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  task check(input [7:0] got, input [7:0] exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(negedge i_clk);
      addr = a;
      wdata = d;
      wr_en = 1;
      @(negedge i_clk);
      wr_en = 0;
    end
  endtask
  task rd(input [7:0] a);
    begin
      @(negedge i_clk);
      addr = a;
      repeat (2) @(negedge i_clk);
      v = rdata;
    end
  endtask
  task idle(input integer n);
    repeat (n) @(negedge i_clk);
  endtask
  task test_done;
    begin
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
        $display("Simulation passed");
      end else begin
        $display("Simulation failed");
      end
      $finish;
    end
  endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (12) @(negedge i_clk);
    i_rstn = 1;
    wr(8'h96, 8'hff);
    for (i = 144; i < 151; i = i + 1) begin
      rd(i[7:0]);
      check(v, 8'h00);
    end
    wr(8'h91, 8'h3b);
    rd(8'h91);
    check(v, 8'h3b);
    wr(8'h91, 8'h00);
    $display("reset and readback done");
    lsel = 1;
    wr(8'h92, 8'h34);
    wr(8'h93, 8'h12);
    wr(8'h94, 8'hfe);
    wr(8'h95, 8'hff);
    wr(8'h91, 8'h04);
    idle(4);
    rd(8'h91);
    check(v, 8'hc4);
    check(v & 8'h40, 8'h40);
    wr(8'h91, 8'hc0);
    rd(8'h91);
    check(v, 8'hc0);
    rd(8'h95);
    check(v, 8'h12);
    check({7'h0, irq}, 8'h00);
    rd(8'h94);
    w = v;
    idle(10);
    rd(8'h94);
    check(v, w);
    irq_en = 1;
    idle(2);
    check({7'h0, irq}, 8'h01);
    rd(8'h91);
    check(v, 8'hc0);
    wr(8'h91, 8'h00);
    idle(2);
    check({7'h0, irq}, 8'h00);
    $display("wide wrap done");
    wr(8'h92, 8'h80);
    wr(8'h94, 8'hfe);
    wr(8'h95, 8'h00);
    wr(8'h91, 8'h28);
    idle(8);
    rd(8'h91);
    check(v, 8'h68);
    rd(8'h95);
    check(v, 8'h00);
    rd(8'h94);
    check(v & 8'h80, 8'h80);
    check({7'h0, irq}, 8'h01);
    wr(8'h91, 8'h08);
    idle(2);
    check({7'h0, irq}, 8'h00);
    wr(8'h94, 8'hfe);
    wr(8'h91, 8'h08);
    rd(8'h91);
    check(v & 8'h40, 8'h40);
    hsel = 1;
    wr(8'h93, 8'h55);
    wr(8'h95, 8'hfe);
    wr(8'h91, 8'h0c);
    idle(3);
    rd(8'h91);
    check(v & 8'h80, 8'h80);
    wr(8'h91, 8'h08);
    rd(8'h95);
    check(v & 8'hf0, 8'h50);
    wr(8'h91, 8'h00);
    $display("split done");
    hsel = 0;
    lsel = 0;
    for (i = 0; i < 2; i = i + 1) begin
      e = i ? 6 : 8;
      wr(8'h94, 8'h00);
      wr(8'h95, 8'h00);
      wr(8'h91, 8'h04 | i[7:0]);
      repeat (96) begin
        @(negedge i_clk);
        ext = ~ext;
      end
      wr(8'h91, i[7:0]);
      rd(8'h94);
      check({7'h0, v + 1 >= e && v <= e + 1}, 8'h01);
    end
    $display("prescale done");
    lsel = 1;
    wr(8'h92, 8'h00);
    wr(8'h94, 8'h00);
    wr(8'h91, 8'h14);
    idle(2);
    lfo = 0;
    idle(3);
    lfo = 1;
    rd(8'h92);
    check(v, 8'h00);
    wr(8'h91, 8'h16);
    idle(2);
    lfo = 0;
    for (i = 0; i < 8; i = i + 1) begin
      @(negedge i_clk);
      seen = seen | irq;
    end
    wr(8'h91, 8'h00);
    check({7'h0, seen}, 8'h01);
    rd(8'h92);
    check({7'h0, v >= 8'h08 && v <= 8'h40}, 8'h01);
    $display("capture done");
    test_done;
  end
endmodule

// >>> hw/tmr3_consts.vh
// Constants for the third timer control block
`ifndef TMR3_CONSTS_VH
`define TMR3_CONSTS_VH

// ----------------------------------------
// Special-function addresses
// ----------------------------------------
`define TMR3_ADDR_CONTROL 8'h91
`define TMR3_ADDR_RELOAD_LOW 8'h92
`define TMR3_ADDR_RELOAD_HIGH 8'h93
`define TMR3_ADDR_COUNT_LOW 8'h94
`define TMR3_ADDR_COUNT_HIGH 8'h95

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define TMR3_BIT_HIGH_FLAG 7
`define TMR3_BIT_LOW_FLAG 6
`define TMR3_BIT_LOW_IRQ_EN 5
`define TMR3_BIT_CAPTURE_EN 4
`define TMR3_BIT_SPLIT 3
`define TMR3_BIT_RUN 2
`define TMR3_BIT_CAPTURE_SRC 1
`define TMR3_BIT_EXT_CLK 0

// ----------------------------------------
// Reset values and wrap points
// ----------------------------------------
`define TMR3_RESET_BYTE 8'h00
`define TMR3_BYTE_MAX 8'hff
`define TMR3_WORD_MAX 16'hffff

// ----------------------------------------
// Clock dividers
// ----------------------------------------
`define TMR3_SYS_DIV 12
`define TMR3_EXT_DIV 8

`endif

// >>> hw/tmr3_prescale.v
// Prescaler producing the divided system and external clock ticks
`timescale 1ns/1ps
`include "tmr3_consts.vh"

module tmr3_prescale #(
  parameter SYS_DIV = `TMR3_SYS_DIV,
  parameter EXT_DIV = `TMR3_EXT_DIV
) (
  // Clock and reset
  input wire i_clk,
  input wire i_rstn,
  // External clock, already synchronous
  input wire i_ext_clk,
  // Ticks
  output reg o_tick_sys12,
  output reg o_tick_ext8
);

  reg [3:0] sys_count;
  reg [2:0] ext_count;
  reg ext_prev;
  wire ext_rise;

  assign ext_rise = i_ext_clk & ~ext_prev;

  // ----------------------------------------
  // Divide by twelve and by eight
  // ----------------------------------------
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sys_count <= 4'h0;
      ext_count <= 3'h0;
      ext_prev <= 1'b0;
      o_tick_sys12 <= 1'b0;
      o_tick_ext8 <= 1'b0;
    end else begin
      ext_prev <= i_ext_clk;
      o_tick_sys12 <= (sys_count == SYS_DIV[3:0] - 4'h1);
      if (sys_count == SYS_DIV[3:0] - 4'h1) begin
        sys_count <= 4'h0;
      end else begin
        sys_count <= sys_count + 4'h1;
      end
      o_tick_ext8 <= ext_rise && (ext_count == EXT_DIV[2:0] - 3'h1);
      if (ext_rise) begin
        if (ext_count == EXT_DIV[2:0] - 3'h1) begin
          ext_count <= 3'h0;
        end else begin
          ext_count <= ext_count + 3'h1;
        end
      end
    end
  end

endmodule

// >>> hw/tmr3_timer.v
// Third timer: control register, counters, reload and capture
// How it works
// RULE1: High byte wrap sets high flag
// RULE2: Sixteen-bit wrap sets high flag
// RULE3: Enabled high flag requests timer interrupt
// RULE4: Flags cleared only by software writing zero
// RULE5: Low byte wrap always sets low flag
// RULE6: Low flag interrupts when low enable set
// RULE7: Oscillator falling edge captures count, interrupts
// RULE8: Split mode gives two reloading byte timers; code skips their reloads while capture enable set
// RULE9: Timer counts only while run set; code counts the low byte in split mode whether run is set or not
// RULE10: Split mode: run gates high byte only
// RULE11: Capture source one selects oscillator edge
// RULE12: External select picks divide-12 or external/8
// RULE13: Per-byte select bits can force system clock
// RULE14: Control at 0x91, resets zero, fixed order
// RULE15: Sixteen-bit wrap loads reload pair; code skips the reload while capture enable set
// RULE16: Split bytes reload from own reload byte; code skips these reloads while capture enable set
// RULE17: Extended enable bit gates all requests
// RULE18: Hardware set beats same-cycle software clear
`timescale 1ns/1ps
`include "tmr3_consts.vh"

module tmr3_timer (
  // Clock and reset
  input wire i_clk,
  input wire i_rstn,
  // Special-function register port
  input wire [7:0] i_sfr_addr,
  input wire i_sfr_wr,
  input wire [7:0] i_sfr_wdata,
  output reg [7:0] o_sfr_rdata,
  // Clock-control select bits and interrupt enable
  input wire i_high_byte_clock_select,
  input wire i_low_byte_clock_select,
  input wire i_extended_irq_enable_one,
  // Clock sources
  input wire i_ext_clk,
  input wire i_lfo_out,
  // Interrupt request
  output reg o_irq
);

  // ----------------------------------------
  // Register state
  // ----------------------------------------
  reg high_byte_overflow_flag;
  reg low_byte_overflow_flag;
  reg low_byte_irq_enable;
  reg osc_capture_enable;
  reg split_mode_enable;
  reg run_control;
  reg capture_source_select;
  reg external_clock_select;
  reg [7:0] counter_low_byte;
  reg [7:0] counter_high_byte;
  reg [7:0] reload_low_byte;
  reg [7:0] reload_high_byte;
  reg lfo_prev;

  wire tick_sys12;
  wire tick_ext8;
  wire tick_low;
  wire tick_high;
  wire step_low;
  wire step_high;
  wire wrap_low;
  wire wrap_high;
  wire capture_event;
  wire [7:0] control_value;
  wire wr_control;
  wire wr_reload_low;
  wire wr_reload_high;
  wire wr_count_low;
  wire wr_count_high;
  reg [7:0] next_counter_low;
  reg [7:0] next_counter_high;

  assign wr_control = i_sfr_wr && (i_sfr_addr == `TMR3_ADDR_CONTROL);
  assign wr_reload_low = i_sfr_wr && (i_sfr_addr == `TMR3_ADDR_RELOAD_LOW);
  assign wr_reload_high = i_sfr_wr && (i_sfr_addr == `TMR3_ADDR_RELOAD_HIGH);
  assign wr_count_low = i_sfr_wr && (i_sfr_addr == `TMR3_ADDR_COUNT_LOW);
  assign wr_count_high = i_sfr_wr && (i_sfr_addr == `TMR3_ADDR_COUNT_HIGH);

  // RULE14: bit order of control
  assign control_value = {high_byte_overflow_flag, low_byte_overflow_flag, low_byte_irq_enable,
                          osc_capture_enable, split_mode_enable, run_control,
                          capture_source_select, external_clock_select};

  // ----------------------------------------
  // Clock selection
  // ----------------------------------------
  tmr3_prescale #(
    .SYS_DIV(`TMR3_SYS_DIV),
    .EXT_DIV(`TMR3_EXT_DIV)
  ) u_prescale (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_ext_clk(i_ext_clk),
    .o_tick_sys12(tick_sys12),
    .o_tick_ext8(tick_ext8)
  );

  // RULE12: divide-12 or external/8
  // RULE13: per-byte system clock override
  assign tick_low = i_low_byte_clock_select ? 1'b1 : (external_clock_select ? tick_ext8 : tick_sys12);
  assign tick_high = i_high_byte_clock_select ? 1'b1 : (external_clock_select ? tick_ext8 : tick_sys12);

  // RULE9: run gates counting
  // RULE10: low byte free in split
  assign step_low = split_mode_enable ? tick_low : (run_control & tick_low);
  assign step_high = split_mode_enable ? (run_control & tick_high) : (run_control & tick_low);

  // RULE5: low byte wrap any mode
  assign wrap_low = step_low && (counter_low_byte == `TMR3_BYTE_MAX);
  // RULE1: high byte wrap
  // RULE2: full word wrap
  assign wrap_high = split_mode_enable ? (step_high && (counter_high_byte == `TMR3_BYTE_MAX)) :
                     (step_high && ({counter_high_byte, counter_low_byte} == `TMR3_WORD_MAX));

  // RULE7: oscillator falling edge
  // RULE11: source one only
  assign capture_event = osc_capture_enable && capture_source_select && lfo_prev && !i_lfo_out;

  // ----------------------------------------
  // Next counter values
  // ----------------------------------------
  always @* begin
    next_counter_low = counter_low_byte;
    next_counter_high = counter_high_byte;
    if (split_mode_enable) begin
      // RULE8: two independent byte timers
      if (step_low) begin
        // RULE16: low reload byte
        if (wrap_low && !osc_capture_enable) begin
          next_counter_low = reload_low_byte;
        end else begin
          next_counter_low = counter_low_byte + 8'h01;
        end
      end
      if (step_high) begin
        // RULE16: high reload byte
        if (wrap_high && !osc_capture_enable) begin
          next_counter_high = reload_high_byte;
        end else begin
          next_counter_high = counter_high_byte + 8'h01;
        end
      end
    end else if (step_low) begin
      // RULE15: reload pair on wrap
      if (wrap_high && !osc_capture_enable) begin
        next_counter_low = reload_low_byte;
        next_counter_high = reload_high_byte;
      end else begin
        next_counter_low = counter_low_byte + 8'h01;
        if (wrap_low) begin
          next_counter_high = counter_high_byte + 8'h01;
        end
      end
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      high_byte_overflow_flag <= 1'b0;
      low_byte_overflow_flag <= 1'b0;
      low_byte_irq_enable <= 1'b0;
      osc_capture_enable <= 1'b0;
      split_mode_enable <= 1'b0;
      run_control <= 1'b0;
      capture_source_select <= 1'b0;
      external_clock_select <= 1'b0;
      counter_low_byte <= `TMR3_RESET_BYTE;
      counter_high_byte <= `TMR3_RESET_BYTE;
      reload_low_byte <= `TMR3_RESET_BYTE;
      reload_high_byte <= `TMR3_RESET_BYTE;
      lfo_prev <= 1'b0;
    end else begin
      lfo_prev <= i_lfo_out;
      if (wr_control) begin
        low_byte_irq_enable <= i_sfr_wdata[`TMR3_BIT_LOW_IRQ_EN];
        osc_capture_enable <= i_sfr_wdata[`TMR3_BIT_CAPTURE_EN];
        split_mode_enable <= i_sfr_wdata[`TMR3_BIT_SPLIT];
        run_control <= i_sfr_wdata[`TMR3_BIT_RUN];
        capture_source_select <= i_sfr_wdata[`TMR3_BIT_CAPTURE_SRC];
        external_clock_select <= i_sfr_wdata[`TMR3_BIT_EXT_CLK];
      end
      // RULE4: only software clears flags
      // RULE18: hardware set wins
      high_byte_overflow_flag <= wrap_high |
                                 (wr_control ? i_sfr_wdata[`TMR3_BIT_HIGH_FLAG] : high_byte_overflow_flag);
      low_byte_overflow_flag <= wrap_low |
                                (wr_control ? i_sfr_wdata[`TMR3_BIT_LOW_FLAG] : low_byte_overflow_flag);
      counter_low_byte <= wr_count_low ? i_sfr_wdata : next_counter_low;
      counter_high_byte <= wr_count_high ? i_sfr_wdata : next_counter_high;
      // RULE7: latch count into reload
      if (capture_event) begin
        reload_low_byte <= counter_low_byte;
        reload_high_byte <= counter_high_byte;
      end else begin
        if (wr_reload_low) begin
          reload_low_byte <= i_sfr_wdata;
        end
        if (wr_reload_high) begin
          reload_high_byte <= i_sfr_wdata;
        end
      end
    end
  end

  // ----------------------------------------
  // Read data and interrupt
  // ----------------------------------------
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_sfr_rdata <= 8'h00;
      o_irq <= 1'b0;
    end else begin
      case (i_sfr_addr)
        `TMR3_ADDR_CONTROL: begin
          o_sfr_rdata <= control_value;
        end
        `TMR3_ADDR_RELOAD_LOW: begin
          o_sfr_rdata <= reload_low_byte;
        end
        `TMR3_ADDR_RELOAD_HIGH: begin
          o_sfr_rdata <= reload_high_byte;
        end
        `TMR3_ADDR_COUNT_LOW: begin
          o_sfr_rdata <= counter_low_byte;
        end
        `TMR3_ADDR_COUNT_HIGH: begin
          o_sfr_rdata <= counter_high_byte;
        end
        default: begin
          o_sfr_rdata <= 8'h00;
        end
      endcase
      // RULE3: high flag request
      // RULE6: low flag when enabled
      // RULE17: extended enable gates all
      o_irq <= i_extended_irq_enable_one &
               (high_byte_overflow_flag | wrap_high |
                (low_byte_irq_enable & (low_byte_overflow_flag | wrap_low)) |
                capture_event);
    end
  end

endmodule
